// [tsac_pkg.sv]
// Contract
// R1 - Touch-disable command blocks touch/function key input and host notification; here a touch while disabled still relights the backlight
// R2 - Touch-enable command restores touch/function key input and notification
// R3 - Touch disable is volatile; reset re-enables touch and keys
// R4 - Screen control parameter 30h lights backlight, 31h turns it off
// R5 - Touch press while backlight off turns the screen back on
// R6 - Buzzer command is 1B 54 plus parameter: 30h off, 31h steady, 32h beeps
// R7 - Commanded buzzer stops on new buzzer command, stop switch, or quiet screen
// R8 - Menu permission parameter 30h permits, 31h inhibits the system menu
// R9 - Permitted and shown menu lets operator pick transmit or maintenance mode
// R10 - Reset drops commanded menu permission and loads the configuration switch
// R11 - Clear-screen erases all text and graphics drawn by terminal commands
// R12 - After clear the registered screen stays; later updates redraw parts only
// R13 - Size 30h selects 16x8 normal, 31h selects 8x8 half-size characters
// R14 - Size persists until screen change or new size; default normal
// R15 - Enlargement 30h..35h: none, tall, wide, 2x2, 3x3, 4x4 for later text
// R16 - Enlargement persists until screen change or new value; default none
// R17 - Enlargement applies equally to normal and half-size characters
// R18 - Normal-display clears inverse and flashing together
// R19 - Set-inverse sets only inverse; other attributes unchanged
// R20 - End-inverse clears only inverse; flashing untouched
// R21 - Set-flashing sets only flashing; with inverse gives flashing inverse
// R22 - Attributes hold until screen change or new command; plain on new screen
// R23 - End-flashing clears only flashing; inverse untouched
// R24 - Opcodes are constants; unknown opcode or bad parameter changes nothing
// R25 - Host sends whole commands starting with escape, never interleaved
package tsac_pkg;

   // ------------------------------------------------------------
   // Command bytes
   // ------------------------------------------------------------
   localparam logic [7:0] ESC_BYTE     = 8'h1b;
   localparam logic [7:0] OP_BUZZER    = 8'h54;
   // Opcodes not fixed by the command table; adjust per host
   localparam logic [7:0] OP_TOUCH_DIS = 8'h55;
   localparam logic [7:0] OP_TOUCH_EN  = 8'h56;
   localparam logic [7:0] OP_SCREEN    = 8'h50;
   localparam logic [7:0] OP_MENU      = 8'h57;
   localparam logic [7:0] OP_CLEAR     = 8'h21;
   localparam logic [7:0] OP_SIZE      = 8'h22;
   localparam logic [7:0] OP_ENLARGE   = 8'h23;
   localparam logic [7:0] OP_NORMAL    = 8'h24;
   localparam logic [7:0] OP_INV_SET   = 8'h25;
   localparam logic [7:0] OP_INV_END   = 8'h26;
   localparam logic [7:0] OP_FLASH_SET = 8'h29;
   localparam logic [7:0] OP_FLASH_END = 8'h2a;

   // ------------------------------------------------------------
   // Parameter characters
   // ------------------------------------------------------------
   localparam logic [7:0] PARAM_0   = 8'h30;
   localparam logic [7:0] PARAM_1   = 8'h31;
   localparam logic [7:0] PARAM_2   = 8'h32;
   localparam logic [7:0] PARAM_MAX = 8'h35;

   // ------------------------------------------------------------
   // Register map (AXI4-Lite byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CMD    = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_EVENT  = 8'h08;
   localparam logic [7:0] ADDR_MODE   = 8'h0c;

   // STATUS fields
   localparam int ST_TOUCH_EN = 0;
   localparam int ST_BKLT     = 1;
   localparam int ST_BUZ_LO   = 2;
   localparam int ST_MENU     = 4;
   localparam int ST_SIZE     = 5;
   localparam int ST_ENL_LO   = 6;
   localparam int ST_INV      = 9;
   localparam int ST_FLASH    = 10;
   localparam int ST_BUSY     = 11;
   localparam int ST_CLRCNT   = 16;

   // EVENT fields (write one to signal)
   localparam int EV_TOUCH     = 0;
   localparam int EV_FKEY      = 1;
   localparam int EV_BUZ_STOP  = 2;
   localparam int EV_SCREEN    = 3;
   localparam int EV_QUIET_SCR = 4;
   localparam int EV_MENU_REQ  = 5;

   // MODE fields
   localparam int MODE_SEL = 0;

   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      TSAC_BUZ_OFF,
      TSAC_BUZ_CONT,
      TSAC_BUZ_BEEP
   } tsac_buzz_t;

   typedef enum logic [1:0] {
      TSAC_MODE_RUN,
      TSAC_MODE_XMIT,
      TSAC_MODE_MAINT
   } tsac_mode_t;

   typedef struct packed {
      logic       inverse;
      logic       flashing;
      logic       half_size;
      logic [2:0] enlarge;
   } tsac_attr_t;

endpackage

// [tsac_top.sv]
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module tsac_top
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                clk_en,
   input  wire logic                menu_permit_config_switch,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [7:0]          awaddr,
   input  wire logic                wvalid,
   output logic                     wready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   output logic                     bvalid,
   input  wire logic                bready,
   output logic [1:0]               bresp,
   input  wire logic                arvalid,
   output logic                     arready,
   input  wire logic [7:0]          araddr,
   output logic                     rvalid,
   input  wire logic                rready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     touch_input_en,
   output logic                     touch_notify,
   output logic                     fkey_notify,
   output logic                     backlight_on,
   output tsac_pkg::tsac_buzz_t     buzzer_mode,
   output logic                     menu_permit,
   output logic                     menu_shown,
   output tsac_pkg::tsac_mode_t     menu_mode,
   output logic                     clear_overlay,
   output tsac_pkg::tsac_attr_t     text_attr
);

   // ------------------------------------------------------------
   // Pin synchroniser for the configuration switch
   // ------------------------------------------------------------
   logic sw_s1_reg;
   logic sw_s2_reg;
   logic cfg_loaded_reg;

   always_ff @(posedge aclk)
   begin
      sw_s1_reg <= menu_permit_config_switch;
      sw_s2_reg <= sw_s1_reg;
   end

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------
   logic        aw_have_reg;
   logic        w_have_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;

   wire aw_take  = awvalid && awready;
   wire w_take   = wvalid && wready;
   wire wr_fire  = aw_have_reg && w_have_reg && !bvalid_reg;
   wire wr_cmd   = wr_fire && (aw_addr_reg == tsac_pkg::ADDR_CMD)
                   && w_strb_reg[0];
   wire wr_event = wr_fire && (aw_addr_reg == tsac_pkg::ADDR_EVENT)
                   && w_strb_reg[0];
   wire wr_mode  = wr_fire && (aw_addr_reg == tsac_pkg::ADDR_MODE)
                   && w_strb_reg[0];
   wire wr_known = (aw_addr_reg == tsac_pkg::ADDR_CMD)
                   || (aw_addr_reg == tsac_pkg::ADDR_EVENT)
                   || (aw_addr_reg == tsac_pkg::ADDR_MODE)
                   || (aw_addr_reg == tsac_pkg::ADDR_STATUS);

   assign awready = clk_en && !aw_have_reg;
   assign wready  = clk_en && !w_have_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= tsac_pkg::AXI_OKAY;
      end
      else if (clk_en)
      begin
         if (aw_take)
         begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= {awaddr[7:2], 2'b00};
         end
         if (w_take)
         begin
            w_have_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         if (wr_fire)
         begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_known ? tsac_pkg::AXI_OKAY
                                    : tsac_pkg::AXI_SLVERR;
         end
         else if (bvalid_reg && bready)
            bvalid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Command byte parser
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      TSAC_P_IDLE,
      TSAC_P_OP,
      TSAC_P_PARAM
   } tsac_pstate_t;

   tsac_pstate_t pstate_reg;
   logic [7:0]   op_reg;

   wire [7:0] cbyte = w_data_reg[7:0];

   function automatic logic needs_param(input logic [7:0] op);
      needs_param = (op == tsac_pkg::OP_SCREEN) || (op == tsac_pkg::OP_BUZZER)
                 || (op == tsac_pkg::OP_MENU) || (op == tsac_pkg::OP_SIZE)
                 || (op == tsac_pkg::OP_ENLARGE);
   endfunction

   function automatic logic in_range(input logic [7:0] c,
                                     input logic [7:0] hi);
      in_range = (c >= tsac_pkg::PARAM_0) && (c <= hi);
   endfunction

   wire op_byte  = wr_cmd && (pstate_reg == TSAC_P_OP);
   wire par_byte = wr_cmd && (pstate_reg == TSAC_P_PARAM);
   wire exec0    = op_byte && !needs_param(cbyte);
   wire [7:0] xop = exec0 ? cbyte : op_reg;
   wire exec1    = par_byte;

   // Escape restarts outside the parameter state; there any byte ends the command, so a broken sequence cannot wedge the parser
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pstate_reg <= TSAC_P_IDLE;
         op_reg     <= 8'h00;
      end
      else if (clk_en && wr_cmd)
      begin
         if (cbyte == tsac_pkg::ESC_BYTE && pstate_reg != TSAC_P_PARAM)
            pstate_reg <= TSAC_P_OP;
         else if (op_byte && needs_param(cbyte))
         begin
            pstate_reg <= TSAC_P_PARAM;
            op_reg     <= cbyte;
         end
         else
            pstate_reg <= TSAC_P_IDLE; // R24
      end
   end

   // ------------------------------------------------------------
   // Decoded actions
   // ------------------------------------------------------------
   wire e_tdis  = exec0 && xop == tsac_pkg::OP_TOUCH_DIS;
   wire e_ten   = exec0 && xop == tsac_pkg::OP_TOUCH_EN;
   wire e_clr   = exec0 && xop == tsac_pkg::OP_CLEAR;
   wire e_norm  = exec0 && xop == tsac_pkg::OP_NORMAL;
   wire e_iset  = exec0 && xop == tsac_pkg::OP_INV_SET;
   wire e_iend  = exec0 && xop == tsac_pkg::OP_INV_END;
   wire e_fset  = exec0 && xop == tsac_pkg::OP_FLASH_SET;
   wire e_fend  = exec0 && xop == tsac_pkg::OP_FLASH_END;
   wire e_scr   = exec1 && xop == tsac_pkg::OP_SCREEN
                  && in_range(cbyte, tsac_pkg::PARAM_1);
   wire e_buz   = exec1 && xop == tsac_pkg::OP_BUZZER
                  && in_range(cbyte, tsac_pkg::PARAM_2);
   wire e_menu  = exec1 && xop == tsac_pkg::OP_MENU
                  && in_range(cbyte, tsac_pkg::PARAM_1);
   wire e_size  = exec1 && xop == tsac_pkg::OP_SIZE
                  && in_range(cbyte, tsac_pkg::PARAM_1);
   wire e_enl   = exec1 && xop == tsac_pkg::OP_ENLARGE
                  && in_range(cbyte, tsac_pkg::PARAM_MAX);

   wire ev_touch = wr_event && w_data_reg[tsac_pkg::EV_TOUCH];
   wire ev_fkey  = wr_event && w_data_reg[tsac_pkg::EV_FKEY];
   wire ev_bstop = wr_event && w_data_reg[tsac_pkg::EV_BUZ_STOP];
   wire ev_scr   = wr_event && w_data_reg[tsac_pkg::EV_SCREEN];
   wire ev_quiet = wr_event && w_data_reg[tsac_pkg::EV_QUIET_SCR];
   wire ev_menu  = wr_event && w_data_reg[tsac_pkg::EV_MENU_REQ];

   // ------------------------------------------------------------
   // Status state
   // ------------------------------------------------------------
   logic                 touch_en_reg;
   logic                 bklt_reg;
   tsac_pkg::tsac_buzz_t buz_reg;
   logic                 menu_reg;
   logic                 shown_reg;
   tsac_pkg::tsac_mode_t mode_reg;
   logic                 clr_reg;
   logic [15:0]          clr_cnt_reg;
   tsac_pkg::tsac_attr_t attr_reg;
   logic                 tnot_reg;
   logic                 fnot_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         touch_en_reg   <= 1'b1; // R3
         bklt_reg       <= 1'b1;
         buz_reg        <= tsac_pkg::TSAC_BUZ_OFF;
         menu_reg       <= 1'b0;
         cfg_loaded_reg <= 1'b0;
         shown_reg      <= 1'b0;
         mode_reg       <= tsac_pkg::TSAC_MODE_RUN;
         clr_reg        <= 1'b0;
         clr_cnt_reg    <= 16'h0000;
         attr_reg       <= '0; // R14 R16 R22
         tnot_reg       <= 1'b0;
         fnot_reg       <= 1'b0;
      end
      else if (clk_en)
      begin
         // Switch level taken once after release, never under reset
         if (!cfg_loaded_reg)
         begin
            cfg_loaded_reg <= 1'b1;
            menu_reg       <= !sw_s2_reg; // R10
         end
         else if (e_menu)
            menu_reg <= (cbyte == tsac_pkg::PARAM_0); // R8

         if (e_tdis)
            touch_en_reg <= 1'b0; // R1
         else if (e_ten)
            touch_en_reg <= 1'b1; // R2

         tnot_reg <= ev_touch && touch_en_reg; // R1
         fnot_reg <= ev_fkey && touch_en_reg; // R1

         if (e_scr)
            bklt_reg <= (cbyte == tsac_pkg::PARAM_0); // R4
         else if (ev_touch && !bklt_reg)
            bklt_reg <= 1'b1; // R5

         if (e_buz)
            buz_reg <= tsac_pkg::tsac_buzz_t'(cbyte[1:0]); // R6 R7
         else if (ev_bstop || ev_quiet)
            buz_reg <= tsac_pkg::TSAC_BUZ_OFF; // R7

         // Menu only appears while permitted; inhibit drops it
         if (!menu_reg)
            shown_reg <= 1'b0;
         else if (ev_menu)
            shown_reg <= 1'b1;
         if (wr_mode && shown_reg && menu_reg)
            mode_reg <= tsac_pkg::tsac_mode_t'(w_data_reg[1:0]); // R9

         // Overlay clear pulse; registered screen itself untouched
         clr_reg <= e_clr; // R11 R12
         if (e_clr)
            clr_cnt_reg <= clr_cnt_reg + 16'h0001; // R11

         if (ev_scr || ev_quiet)
            attr_reg <= '0; // R14 R16 R22
         else
         begin
            if (e_size)
               attr_reg.half_size <= cbyte[0]; // R13
            if (e_enl)
               attr_reg.enlarge <= cbyte[2:0]; // R15 R17
            if (e_norm)
            begin
               attr_reg.inverse  <= 1'b0; // R18
               attr_reg.flashing <= 1'b0; // R18
            end
            if (e_iset)
               attr_reg.inverse <= 1'b1; // R19
            if (e_iend)
               attr_reg.inverse <= 1'b0; // R20
            if (e_fset)
               attr_reg.flashing <= 1'b1; // R21
            if (e_fend)
               attr_reg.flashing <= 1'b0; // R23
         end
      end
   end

   assign touch_input_en = touch_en_reg;
   assign touch_notify   = tnot_reg;
   assign fkey_notify    = fnot_reg;
   assign backlight_on   = bklt_reg;
   assign buzzer_mode    = buz_reg;
   assign menu_permit    = menu_reg;
   assign menu_shown     = shown_reg;
   assign menu_mode      = mode_reg;
   assign clear_overlay  = clr_reg;
   assign text_attr      = attr_reg;

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   wire [7:0]  ra = {araddr[7:2], 2'b00};
   wire [31:0] status_word = {clr_cnt_reg, 4'h0, pstate_reg != TSAC_P_IDLE,
                              attr_reg.flashing, attr_reg.inverse,
                              attr_reg.enlarge, attr_reg.half_size,
                              menu_reg, buz_reg, bklt_reg, touch_en_reg};
   wire [31:0] mode_word = {29'h0, shown_reg, mode_reg};

   assign arready = clk_en && !rvalid_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= tsac_pkg::AXI_OKAY;
      end
      else if (clk_en)
      begin
         if (arvalid && arready)
         begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= tsac_pkg::AXI_OKAY;
            if (ra == tsac_pkg::ADDR_STATUS)
               rdata_reg <= status_word;
            else if (ra == tsac_pkg::ADDR_MODE)
               rdata_reg <= mode_word;
            else if (ra == tsac_pkg::ADDR_CMD || ra == tsac_pkg::ADDR_EVENT)
               rdata_reg <= 32'h0000_0000;
            else
            begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= tsac_pkg::AXI_SLVERR;
            end
         end
         else if (rvalid_reg && rready)
            rvalid_reg <= 1'b0;
      end
   end

endmodule

// [tsac_chk.sv]
`timescale 1ns/1ps
module tsac_chk
(
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire logic                 clk_en,
   input wire logic                 awready,
   input wire logic                 wready,
   input wire logic                 arvalid,
   input wire logic                 arready,
   input wire logic [7:0]           araddr,
   input wire logic                 bvalid,
   input wire logic                 rvalid,
   input wire logic [1:0]           rresp,
   input wire logic                 touch_input_en,
   input wire logic                 touch_notify,
   input wire logic                 fkey_notify,
   input wire logic                 backlight_on,
   input wire tsac_pkg::tsac_buzz_t buzzer_mode,
   input wire logic                 menu_permit,
   input wire logic                 menu_shown,
   input wire tsac_pkg::tsac_mode_t menu_mode,
   input wire logic                 clear_overlay,
   input wire tsac_pkg::tsac_attr_t text_attr
);
   // ------------------------------------------------------------
   // Touch enable, backlight, buzzer and attributes move only when a write completes
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_notify_gated: assert property (
      (touch_notify || fkey_notify) |-> touch_input_en)
      else $error("notify while input disabled");
   a_touch_cause: assert property (
      $changed(touch_input_en) |-> $rose(bvalid))
      else $error("touch enable moved without a write");
   a_bklt_cause: assert property (
      $changed(backlight_on) |-> $rose(bvalid))
      else $error("backlight moved without a write");
   a_buzz_cause: assert property (
      $changed(buzzer_mode) |-> $rose(bvalid))
      else $error("buzzer moved without a write");
   a_attr_cause: assert property (
      $changed(text_attr) |-> $rose(bvalid))
      else $error("attributes moved without a write");
   a_clear_pulse: assert property (
      clear_overlay |-> $rose(bvalid) ##1 !clear_overlay)
      else $error("clear pulse malformed");
   a_mode_gate: assert property (
      $changed(menu_mode) |-> $past(menu_shown) && $past(menu_permit))
      else $error("mode changed without shown menu");
   a_unmapped_err: assert property (
      arvalid && arready && araddr > 8'h0f
      |=> rvalid && rresp == tsac_pkg::AXI_SLVERR)
      else $error("unmapped read not refused");
   a_rd_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   a_stall_ready: assert property (!clk_en |-> !awready && !wready && !arready)
      else $error("ready while frozen");

   c_clear: cover property (clear_overlay);
   c_maint: cover property (menu_mode == tsac_pkg::TSAC_MODE_MAINT);
   c_flash_inv: cover property (text_attr.inverse && text_attr.flashing);
endmodule

bind tsac_top tsac_chk u_chk (.*);

// [tsac_host.sv]
`timescale 1ns/1ps
module tsac_host
(
   input  wire logic        aclk,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [7:0]       awaddr,
   output logic             wvalid,
   input  wire logic        wready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   input  wire logic        bvalid,
   output logic             bready,
   input  wire logic [1:0]  bresp,
   output logic             arvalid,
   input  wire logic        arready,
   output logic [7:0]       araddr,
   input  wire logic        rvalid,
   output logic             rready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp
);
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hf;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while (awvalid || wvalid);
      // Released payload must not look valid
      awaddr <= ~a;
      wdata <= ~d;
      do
         @(posedge aclk);
      while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do
         @(posedge aclk);
      while (!arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      do
         @(posedge aclk);
      while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // Whole command, escape first, never interleaved
   task automatic cmd(input logic [7:0] op, input logic [7:0] p,
      input logic np);
      logic [1:0] r;
      wr(tsac_pkg::ADDR_CMD, {24'h0, tsac_pkg::ESC_BYTE}, r);
      wr(tsac_pkg::ADDR_CMD, {24'h0, op}, r);
      if (np)
         wr(tsac_pkg::ADDR_CMD, {24'h0, p}, r);
   endtask
endmodule

// [tsac_top_tb.sv]
`timescale 1ns/1ps
module tsac_top_tb;
   logic                 aclk, aresetn, clk_en, menu_permit_config_switch;
   logic                 awvalid, awready, wvalid, wready, bvalid, bready;
   logic                 arvalid, arready, rvalid, rready, menu_shown;
   logic                 touch_input_en, touch_notify, fkey_notify;
   logic                 backlight_on, menu_permit, clear_overlay;
   logic                 eten, ebl, ep;
   logic [7:0]           awaddr, araddr, p;
   logic [31:0]          wdata, rdata, d, seed;
   logic [3:0]           wstrb;
   logic [1:0]           bresp, rresp, r, eb;
   tsac_pkg::tsac_buzz_t buzzer_mode;
   tsac_pkg::tsac_mode_t menu_mode;
   tsac_pkg::tsac_attr_t text_attr, ea;
   int                   n_fail = 0, samples_checked = 0, n_clr = 0;
   int                   n_tch = 0, n_fk = 0, n_co = 0;
   localparam logic [7:0] OPS [0:6] = '{tsac_pkg::OP_SIZE,
      tsac_pkg::OP_ENLARGE, tsac_pkg::OP_NORMAL, tsac_pkg::OP_INV_SET,
      tsac_pkg::OP_INV_END, tsac_pkg::OP_FLASH_SET, tsac_pkg::OP_FLASH_END};

   tsac_top DUT (.*);
   tsac_host u_host (.*);

   initial
   begin
      aclk = 1'b0;
      forever
         #4 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      n_tch += touch_notify;
      n_fk += fkey_notify;
      n_co += clear_overlay;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic tsac_pkg::tsac_attr_t nx(input tsac_pkg::tsac_attr_t a,
      input logic [7:0] op, input logic [7:0] p);
      case (op)
         tsac_pkg::OP_SIZE:
            if (p < 8'h32 && p > 8'h2f)
               a.half_size = p[0];
         tsac_pkg::OP_ENLARGE:
            if (p < 8'h36 && p > 8'h2f)
               a.enlarge = p[2:0];
         tsac_pkg::OP_NORMAL: a[5:4] = 2'b00;
         tsac_pkg::OP_INV_SET: a.inverse = 1'b1;
         tsac_pkg::OP_INV_END: a.inverse = 1'b0;
         tsac_pkg::OP_FLASH_SET: a.flashing = 1'b1;
         tsac_pkg::OP_FLASH_END: a.flashing = 1'b0;
         default: ;
      endcase
      return a;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic ev(input int b);
      u_host.wr(tsac_pkg::ADDR_EVENT, 32'h1 << b, r);
      repeat (2) @(posedge aclk);
   endtask

   // Switch held through the whole reset so its synchroniser settles
   task automatic rst(input logic s);
      menu_permit_config_switch <= s;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      {eten, ebl, ep, eb, ea} = {2'b11, ~s, 8'h00};
      n_clr = 0;
   endtask

   task automatic st();
      u_host.rd(tsac_pkg::ADDR_STATUS, d, r);
      chk({d[31:16], d[11:0]}, {n_clr[15:0], 1'b0, ea.flashing, ea.inverse,
         ea.enlarge, ea.half_size, ep, eb, ebl, eten});
      chk({touch_input_en, backlight_on, buzzer_mode, menu_permit, text_attr},
         {eten, ebl, eb, ep, ea});
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      test_done();
   end

   initial
   begin
      {aresetn, clk_en, menu_permit_config_switch} = 3'b011;
      seed = 32'hc293dd07;
      rst(1'b1);
      st();
      u_host.cmd(tsac_pkg::OP_MENU, 8'h30, 1'b1);
      ev(tsac_pkg::EV_MENU_REQ);
      for (int m = 2; m > 0; m--)
      begin
         u_host.wr(tsac_pkg::ADDR_MODE, 32'(m), r);
         chk({menu_shown, menu_mode}, 32'(m + 4));
      end
      u_host.cmd(tsac_pkg::OP_MENU, 8'h31, 1'b1);
      u_host.wr(tsac_pkg::ADDR_MODE, 32'h2, r);
      chk({menu_permit, menu_mode}, 32'h1);
      ev(tsac_pkg::EV_TOUCH);
      ev(tsac_pkg::EV_FKEY);
      u_host.cmd(tsac_pkg::OP_TOUCH_DIS, 8'h00, 1'b0);
      ev(tsac_pkg::EV_TOUCH);
      ev(tsac_pkg::EV_FKEY);
      chk({n_tch[14:0], n_fk[15:0], touch_input_en}, 32'h0002_0002);
      for (int i = 0; i < 4; i++)
      begin
         p = (i == 3) ? 8'h30 : 8'h31 + 8'(i);
         u_host.cmd(tsac_pkg::OP_SCREEN, p, 1'b1);
         chk(backlight_on, i == 3);
      end
      u_host.cmd(tsac_pkg::OP_SCREEN, 8'h31, 1'b1);
      ev(tsac_pkg::EV_TOUCH);
      chk(backlight_on, 1'b1);
      u_host.cmd(tsac_pkg::OP_TOUCH_EN, 8'h00, 1'b0);
      ev(tsac_pkg::EV_TOUCH);
      chk(n_tch, 2);
      for (int i = 1; i < 5; i++)
      begin
         p = 8'h30 + 8'(i % 4);
         u_host.cmd(tsac_pkg::OP_BUZZER, p, 1'b1);
         if (p != 8'h33)
            eb = p[1:0];
         chk(buzzer_mode, eb);
      end
      u_host.cmd(tsac_pkg::OP_BUZZER, 8'h31, 1'b1);
      ev(tsac_pkg::EV_BUZ_STOP);
      chk(buzzer_mode, 2'd0);
      u_host.cmd(tsac_pkg::OP_BUZZER, 8'h32, 1'b1);
      ev(tsac_pkg::EV_SCREEN);
      chk(buzzer_mode, 2'd2);
      ev(tsac_pkg::EV_QUIET_SCR);
      chk(buzzer_mode, 2'd0);
      for (int i = 0; i < 80; i++)
      begin
         seed = xs(seed);
         p = 8'h2f + 8'(seed[10:8]);
         if (seed[2:0] != 3'd7)
         begin
            u_host.cmd(OPS[seed[2:0]], p, seed[2:0] < 3'd2);
            ea = nx(ea, OPS[seed[2:0]], p);
         end
         else if (seed[3])
         begin
            ev(tsac_pkg::EV_SCREEN);
            ea = '0;
         end
         else
            u_host.cmd({4'h6, seed[7:4]}, p, 1'b0);
         chk(text_attr, ea);
      end
      u_host.cmd(tsac_pkg::OP_CLEAR, 8'h00, 1'b0);
      n_clr++;
      repeat (2) @(posedge aclk);
      chk(n_co, n_clr);
      st();
      u_host.rd(8'h10, d, r);
      chk(r, tsac_pkg::AXI_SLVERR);
      u_host.wr(8'h14, 32'h31, r);
      chk(r, tsac_pkg::AXI_SLVERR);
      clk_en <= 1'b0;
      repeat (3) @(posedge aclk);
      clk_en <= 1'b1;
      u_host.cmd(tsac_pkg::OP_TOUCH_DIS, 8'h00, 1'b0);
      rst(1'b0);
      st();
      test_done();
   end
endmodule
